// ==== hw/brk_pkg.sv ====
// Contract
// RL1 - Channel B ASID mask 0 compares all ASID bits; 1 skips the check.
// RL2 - Unused bits 19-16, 9-8, 5-4, 2-1 read as zero.
// RL3 - Software writes zero to every unused bit.
// RL4 - CPU match flags A and B set on CPU cycle match, never self-cleared.
// RL5 - DMA match flags A and B set on DMA cycle match, never self-cleared.
// RL6 - Match flags clear only when software writes zero to them.
// RL7 - Branch tracing runs only while trace enable is one; reset off.
// RL8 - Channel A fetch break before execution when bit 10 zero, else after.
// RL9 - Channel B fetch break before execution when bit 6 zero, else after.
// RL10 - Channel B data compare counts only when bit 7 is one.
// RL11 - Sequence bit zero: channels independent; one: A then B.
// RL12 - Count enable one: channel B breaks only when count reached.
// RL13 - Count decrements per B match; break on match when count is one.
// RL14 - Channel A ASID mask bit 21 works like bit 20 for B.
// RL15 - Reset returns the whole control register to zero.
// RL16 - Sequential mode remembers A match; break on later B; then clears.
package brk_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_MASK    = 4'hC;
    localparam int BIT_ASID_MASK_A  = 21;
    localparam int BIT_ASID_MASK_B  = 20;
    localparam int BIT_CPU_FLAG_A   = 15;
    localparam int BIT_CPU_FLAG_B   = 14;
    localparam int BIT_DMA_FLAG_A   = 13;
    localparam int BIT_DMA_FLAG_B   = 12;
    localparam int BIT_TRACE_EN     = 11;
    localparam int BIT_AFTER_A      = 10;
    localparam int BIT_DATA_EN_B    = 7;
    localparam int BIT_AFTER_B      = 6;
    localparam int BIT_SEQ          = 3;
    localparam int BIT_COUNT_EN     = 0;
    localparam logic [31:0] CONTROL_WMASK = 32'h0030FCC9;
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
    localparam logic [11:0] COUNT_RESET   = 12'h000;
    localparam logic [11:0] COUNT_ONE     = 12'h001;
    localparam int STATUS_W = 3;
    localparam int EV_BREAK   = 0;
    localparam int EV_FLAG    = 1;
    localparam int EV_COUNT   = 2;
endpackage

// ==== hw/brk_chan_match.sv ====
module brk_chan_match
(
    // Cycle
    input  wire logic       asidEq,
    input  wire logic       dataEq,
    input  wire logic       addrHit,
    // Control
    input  wire logic       asidMask,
    input  wire logic       dataUse,
    // Result
    output logic            hit
);
    // ASID and data terms drop out when masked
    assign hit = addrHit && (asidMask || asidEq) && (!dataUse || dataEq);
endmodule // brk_chan_match

// ==== hw/brk_irq.sv ====
module brk_irq
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Events and software
    input  wire logic [brk_pkg::STATUS_W-1:0] ev,
    input  wire logic                      rdClr,
    input  wire logic [brk_pkg::STATUS_W-1:0] maskIn,
    // Status
    output logic [brk_pkg::STATUS_W-1:0]   status_reg,
    output logic                           irq_reg
);
    logic [brk_pkg::STATUS_W-1:0] status_next;
    // New events win over a clearing read
    assign status_next = (rdClr ? '0 : status_reg) | ev;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_reg <= '0;
            irq_reg    <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            irq_reg    <= |(status_next & maskIn);
        end
    end
endmodule // brk_irq

// ==== hw/brk_control.sv ====
module brk_control
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    // Channel A cycle compare results
    input  wire logic        aAddrHit,
    input  wire logic        aAsidEq,
    input  wire logic        aFetch,
    // Channel B cycle compare results
    input  wire logic        bAddrHit,
    input  wire logic        bAsidEq,
    input  wire logic        bDataEq,
    input  wire logic        bFetch,
    // Bus cycle owner, one for DMA
    input  wire logic        cycleDma,
    input  wire logic        cycleValid,
    // Break outputs
    output logic             breakA,
    output logic             breakB,
    output logic             breakAfter,
    output logic             traceEnable,
    output logic             irq
);
    logic [31:0] control_reg;
    logic [11:0] count_reg;
    logic [brk_pkg::STATUS_W-1:0] imask_reg;
    logic [brk_pkg::STATUS_W-1:0] status;
    logic [brk_pkg::STATUS_W-1:0] ev;
    logic        irqQ;
    logic        seqArmed_reg;
    logic        hitA;
    logic        hitB;
    logic        condA;
    logic        condB;
    logic        countGate;
    logic        fireA;
    logic        fireB;
    logic        wrCtl;
    logic        rdStatus;

    assign wrCtl    = regWr && regAddr == brk_pkg::ADDR_CONTROL;
    assign rdStatus = regRd && regAddr == brk_pkg::ADDR_STATUS;

    brk_chan_match uChanA
    (
        .asidEq   (aAsidEq),
        .dataEq   (1'b1),
        .addrHit  (aAddrHit && cycleValid),
        .asidMask (control_reg[brk_pkg::BIT_ASID_MASK_A]), // RL14
        .dataUse  (1'b0),
        .hit      (hitA)
    );

    brk_chan_match uChanB
    (
        .asidEq   (bAsidEq),
        .dataEq   (bDataEq),
        .addrHit  (bAddrHit && cycleValid),
        .asidMask (control_reg[brk_pkg::BIT_ASID_MASK_B]), // RL1
        .dataUse  (control_reg[brk_pkg::BIT_DATA_EN_B]),   // RL10
        .hit      (hitB)
    );

    // Sequential mode: A only arms, B breaks once armed
    assign condA = hitA && !control_reg[brk_pkg::BIT_SEQ]; // RL11
    assign condB = hitB && (!control_reg[brk_pkg::BIT_SEQ] || seqArmed_reg); // RL11 RL16
    // Count gate: pass when disabled or count at one (or zero)
    assign countGate = !control_reg[brk_pkg::BIT_COUNT_EN] ||
                       count_reg <= brk_pkg::COUNT_ONE; // RL12 RL13
    assign fireA = condA;
    assign fireB = condB && countGate; // RL12

    // Control register with sticky match flags
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            control_reg <= brk_pkg::CONTROL_RESET; // RL15
        end
        else
        begin
            if (wrCtl)
            begin
                control_reg <= regWdata & brk_pkg::CONTROL_WMASK; // RL6 RL2
            end
            // Set wins over a clearing write
            if (hitA && !cycleDma)
                control_reg[brk_pkg::BIT_CPU_FLAG_A] <= 1'b1; // RL4
            if (hitB && !cycleDma)
                control_reg[brk_pkg::BIT_CPU_FLAG_B] <= 1'b1; // RL4
            if (hitA && cycleDma)
                control_reg[brk_pkg::BIT_DMA_FLAG_A] <= 1'b1; // RL5
            if (hitB && cycleDma)
                control_reg[brk_pkg::BIT_DMA_FLAG_B] <= 1'b1; // RL5
        end
    end

    // Execution count, decremented per channel B match while count enable is one and the count is above one
    always_ff @(posedge mclk)
    begin
        if (rst)
            count_reg <= brk_pkg::COUNT_RESET;
        else if (regWr && regAddr == brk_pkg::ADDR_COUNT)
            count_reg <= regWdata[11:0];
        else if (condB && control_reg[brk_pkg::BIT_COUNT_EN] &&
                 count_reg > brk_pkg::COUNT_ONE)
            count_reg <= count_reg - 12'h001; // RL13
    end

    // Sequence memory
    always_ff @(posedge mclk)
    begin
        if (rst || !control_reg[brk_pkg::BIT_SEQ])
            seqArmed_reg <= 1'b0;
        else if (fireB)
            seqArmed_reg <= 1'b0; // RL16
        else if (hitA)
            seqArmed_reg <= 1'b1; // RL16
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            imask_reg <= '0;
        else if (regWr && regAddr == brk_pkg::ADDR_MASK)
            imask_reg <= regWdata[brk_pkg::STATUS_W-1:0];
    end

    // Break outputs, timing from fetch-after bits
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            breakA      <= 1'b0;
            breakB      <= 1'b0;
            breakAfter  <= 1'b0;
            traceEnable <= 1'b0;
        end
        else
        begin
            breakA      <= fireA;
            breakB      <= fireB;
            breakAfter  <= (fireA && aFetch &&
                            control_reg[brk_pkg::BIT_AFTER_A]) || // RL8
                           (fireB && bFetch &&
                            control_reg[brk_pkg::BIT_AFTER_B]);   // RL9
            traceEnable <= control_reg[brk_pkg::BIT_TRACE_EN];    // RL7
        end
    end

    assign ev[brk_pkg::EV_BREAK] = fireA || fireB;
    assign ev[brk_pkg::EV_FLAG]  = hitA || hitB;
    assign ev[brk_pkg::EV_COUNT] = condB && control_reg[brk_pkg::BIT_COUNT_EN];

    brk_irq uIrq
    (
        .mclk       (mclk),
        .rst        (rst),
        .ev         (ev),
        .rdClr      (rdStatus),
        .maskIn     (imask_reg),
        .status_reg (status),
        .irq_reg    (irqQ)
    );
    assign irq = irqQ;

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (rst)
            regRdata <= '0;
        else if (regRd)
        begin
            case (regAddr)
                brk_pkg::ADDR_CONTROL: regRdata <= control_reg; // RL2
                brk_pkg::ADDR_COUNT:   regRdata <= {20'h00000, count_reg};
                brk_pkg::ADDR_STATUS:
                    regRdata <= {29'h0000000, status};
                brk_pkg::ADDR_MASK:
                    regRdata <= {29'h0000000, imask_reg};
                default:               regRdata <= '0;
            endcase
        end
        else
            regRdata <= '0;
    end

    property p_flag_sticky;
        @(posedge mclk) disable iff (rst)
        control_reg[brk_pkg::BIT_CPU_FLAG_A] && !wrCtl |=>
            control_reg[brk_pkg::BIT_CPU_FLAG_A];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RL4
        else $error("flag A lost");

    property p_dma_set;
        @(posedge mclk) disable iff (rst)
        hitB && cycleDma |=> control_reg[brk_pkg::BIT_DMA_FLAG_B];
    endproperty
    a_dma_set: assert property (p_dma_set) // RL5
        else $error("DMA flag B not set");

    property p_clear_only_write;
        @(posedge mclk) disable iff (rst)
        control_reg[brk_pkg::BIT_CPU_FLAG_B] && !wrCtl |=>
            control_reg[brk_pkg::BIT_CPU_FLAG_B];
    endproperty
    a_clear_only_write: assert property (p_clear_only_write) // RL6
        else $error("flag cleared without write");

    property p_reserved_zero;
        @(posedge mclk) disable iff (rst)
        (control_reg & ~brk_pkg::CONTROL_WMASK) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RL2
        else $error("reserved bit set");

    property p_trace;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> traceEnable == $past(control_reg[brk_pkg::BIT_TRACE_EN]);
    endproperty
    a_trace: assert property (p_trace) // RL7
        else $error("trace enable mismatch");

    property p_seq_hold;
        @(posedge mclk) disable iff (rst)
        control_reg[brk_pkg::BIT_SEQ] && !seqArmed_reg |=> !breakB;
    endproperty
    a_seq_hold: assert property (p_seq_hold) // RL16
        else $error("B break without A");

    property p_count_block;
        @(posedge mclk) disable iff (rst)
        control_reg[brk_pkg::BIT_COUNT_EN] &&
            count_reg > brk_pkg::COUNT_ONE |=> !breakB;
    endproperty
    a_count_block: assert property (p_count_block) // RL12
        else $error("early count break");

    property p_count_dec;
        @(posedge mclk) disable iff (rst)
        condB && control_reg[brk_pkg::BIT_COUNT_EN] && !regWr &&
            count_reg > brk_pkg::COUNT_ONE |=>
            count_reg == $past(count_reg) - 12'h001;
    endproperty
    a_count_dec: assert property (p_count_dec) // RL13
        else $error("count not decremented");

    property p_asid_b;
        @(posedge mclk) disable iff (rst)
        bAddrHit && cycleValid && !bAsidEq &&
            !control_reg[brk_pkg::BIT_ASID_MASK_B] |-> !hitB;
    endproperty
    a_asid_b: assert property (p_asid_b) // RL1
        else $error("ASID B not checked");

    property p_after_a;
        @(posedge mclk) disable iff (rst)
        fireA && aFetch && !control_reg[brk_pkg::BIT_AFTER_A] && !fireB
            |=> !breakAfter;
    endproperty
    a_after_a: assert property (p_after_a) // RL8
        else $error("A timing wrong");

    property p_cpu_set_a;
        @(posedge mclk) disable iff (rst)
        hitA && !cycleDma |=> control_reg[brk_pkg::BIT_CPU_FLAG_A];
    endproperty
    a_cpu_set_a: assert property (p_cpu_set_a) // RL4
        else $error("CPU flag A not set");

    property p_asid_a;
        @(posedge mclk) disable iff (rst)
        aAddrHit && cycleValid && !aAsidEq &&
            !control_reg[brk_pkg::BIT_ASID_MASK_A] |-> !hitA;
    endproperty
    a_asid_a: assert property (p_asid_a) // RL14
        else $error("ASID A not checked");

    property p_after_b;
        @(posedge mclk) disable iff (rst)
        fireB && bFetch && control_reg[brk_pkg::BIT_AFTER_B]
            |=> breakAfter;
    endproperty
    a_after_b: assert property (p_after_b) // RL9
        else $error("B timing wrong");

    // Armed sequence plus a passing B match must break and disarm
    sequence s_seq_armed;
        control_reg[brk_pkg::BIT_SEQ] && seqArmed_reg;
    endsequence

    sequence s_b_pass;
        hitB && countGate;
    endsequence

    property p_seq_fire;
        @(posedge mclk) disable iff (rst)
        s_seq_armed ##0 s_b_pass |=> breakB && !seqArmed_reg;
    endproperty
    a_seq_fire: assert property (p_seq_fire) // RL16
        else $error("armed B match did not break");
endmodule // brk_control

// ==== test/brk_bus_model.sv ====
module brk_bus_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Request from the bench
    input  wire logic       go,
    input  wire logic       dmaIn,
    input  wire logic [6:0] hitsIn,
    // Bus cycle toward the break unit
    output logic            cycleValid,
    output logic            cycleDma,
    output logic [6:0]      hits
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle cycles flip the lines, so ignoring cycleValid cannot pass
    always_ff @(posedge mclk)
    begin
        if (rst || !go)
        begin
            cycleValid <= 1'b0;
            cycleDma   <= rst ? 1'b0 : ~cycleDma;
            hits       <= rst ? 7'h00 : ~hits;
        end
        else
        begin
            cycleValid <= 1'b1;
            cycleDma   <= dmaIn;
            hits       <= hitsIn;
        end
    end
endmodule // brk_bus_model

// ==== test/test_break_control_settings.sv ====
module test_break_control_settings;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic        go = 1'b0;
    logic        dmaIn = 1'b0;
    logic [6:0]  hitsIn = 7'h00;
    logic        cycleValid;
    logic        cycleDma;
    logic [6:0]  hits;
    logic        breakA;
    logic        breakB;
    logic        breakAfter;
    logic        traceEnable;
    logic        irq;
    logic [31:0] rv;
    logic [31:0] expv;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          seed = 32'h6044AD52;
    int          n;

    initial forever #2.5 mclk = ~mclk;

    brk_bus_model bus_u
    (
        .mclk(mclk), .rst(rst), .go(go), .dmaIn(dmaIn), .hitsIn(hitsIn),
        .cycleValid(cycleValid), .cycleDma(cycleDma), .hits(hits)
    );

    brk_control dut_u
    (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .aAddrHit(hits[6]), .aAsidEq(hits[5]), .aFetch(hits[4]),
        .bAddrHit(hits[3]), .bAsidEq(hits[2]), .bDataEq(hits[1]),
        .bFetch(hits[0]), .cycleDma(cycleDma), .cycleValid(cycleValid),
        .breakA(breakA), .breakB(breakB), .breakAfter(breakAfter),
        .traceEnable(traceEnable), .irq(irq)
    );

    task automatic finish_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        begin
            total_checks++;
            if (seen !== exp)
            begin
                err_total++;
                $display("[ERR] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    // Writable fields only; unused bits read back as zero
    function automatic logic [31:0] ctl_exp(input logic [31:0] w);
        return w & 32'h0030FCC9;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        begin
            @(posedge mclk);
            regWr <= 1'b1;
            regAddr <= a;
            regWdata <= d;
            @(posedge mclk);
            regWr <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        begin
            @(posedge mclk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge mclk);
            regRd <= 1'b0;
            #1;
            d = regRdata;
        end
    endtask

    // Hits: aAddr aAsid aFetch bAddr bAsid bData bFetch; exp: A B after
    task automatic cyc(input logic dma, input logic [6:0] h,
                       input logic [2:0] exp);
        begin
            @(posedge mclk);
            go <= 1'b1;
            dmaIn <= dma;
            hitsIn <= h;
            @(posedge mclk);
            go <= 1'b0;
            @(posedge mclk);
            #1;
            chk("breaks", {29'h0, breakA, breakB, breakAfter}, {29'h0, exp});
        end
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test;
        end
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(brk_pkg::ADDR_CONTROL, rv);
        chk("control", rv, 32'h0);
        rd(brk_pkg::ADDR_COUNT, rv);
        chk("count", rv, 32'h0);
        $display("reset test done");
        // Ones in unused bits are a deliberate refusal case
        for (int i = 0; i < 6; i++)
        begin
            expv = $random(seed) & 32'hFFFF0FFF;
            wr(brk_pkg::ADDR_CONTROL, expv);
            rd(brk_pkg::ADDR_CONTROL, rv);
            chk("control", rv, ctl_exp(expv));
            chk("trace", {31'h0, traceEnable}, {31'h0, expv[11]});
        end
        rd(4'h2, rv);
        chk("unmapped", rv, 32'h0);
        $display("field test done");
        wr(brk_pkg::ADDR_CONTROL, 32'h0);
        expv = 32'h0;
        for (int k = 0; k < 4; k++)
        begin
            cyc(k[1], k[0] ? 7'h0E : 7'h60, k[0] ? 3'b010 : 3'b100);
            expv[15 - 2 * k[1] - k[0]] = 1'b1;
            rd(brk_pkg::ADDR_CONTROL, rv);
            chk("flags", rv, expv);
        end
        wr(brk_pkg::ADDR_CONTROL, 32'h0);
        rd(brk_pkg::ADDR_CONTROL, rv);
        chk("flags", rv, 32'h0);
        $display("flag test done");
        cyc(1'b0, 7'h0A, 3'b000);
        cyc(1'b0, 7'h40, 3'b000);
        cyc(1'b0, 7'h0C, 3'b010);
        wr(brk_pkg::ADDR_CONTROL, 32'h00300000);
        cyc(1'b0, 7'h0A, 3'b010);
        cyc(1'b1, 7'h40, 3'b100);
        wr(brk_pkg::ADDR_CONTROL, 32'h00000080);
        cyc(1'b0, 7'h0C, 3'b000);
        cyc(1'b0, 7'h0E, 3'b010);
        wr(brk_pkg::ADDR_CONTROL, 32'h00000400);
        cyc(1'b0, 7'h70, 3'b101);
        cyc(1'b0, 7'h0F, 3'b010);
        wr(brk_pkg::ADDR_CONTROL, 32'h00000040);
        cyc(1'b0, 7'h70, 3'b100);
        cyc(1'b0, 7'h0F, 3'b011);
        $display("condition test done");
        wr(brk_pkg::ADDR_CONTROL, 32'h00000008);
        cyc(1'b0, 7'h0E, 3'b000);
        cyc(1'b0, 7'h60, 3'b000);
        cyc(1'b0, 7'h0E, 3'b010);
        cyc(1'b0, 7'h0E, 3'b000);
        $display("sequence test done");
        n = 2 + ($random(seed) & 3);
        wr(brk_pkg::ADDR_CONTROL, 32'h00000001);
        wr(brk_pkg::ADDR_COUNT, n);
        for (int i = 1; i <= n; i++)
            cyc(1'b0, 7'h0E, (i == n) ? 3'b010 : 3'b000);
        rd(brk_pkg::ADDR_COUNT, rv);
        chk("count", rv, 32'h1);
        wr(brk_pkg::ADDR_CONTROL, 32'h0);
        cyc(1'b0, 7'h0E, 3'b010);
        $display("count test done");
        chk("irq", {31'h0, irq}, 32'h0);
        rd(brk_pkg::ADDR_STATUS, rv);
        chk("status", rv, 32'h7);
        wr(brk_pkg::ADDR_MASK, 32'h1);
        rd(brk_pkg::ADDR_MASK, rv);
        chk("mask", rv, 32'h1);
        cyc(1'b0, 7'h0E, 3'b010);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        rd(brk_pkg::ADDR_STATUS, rv);
        chk("status", rv, 32'h3);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq", {31'h0, irq}, 32'h0);
        $display("interrupt test done");
        finish_test;
    end
endmodule // test_break_control_settings
